// ==== assb_consts.svh ====
// constants for the alarm sticky status bank
`ifndef ASSB_CONSTS_SVH
`define ASSB_CONSTS_SVH

`define ASSB_ADDR_W 16
`define ASSB_ADDR_ALARM_ENABLE 16'h00C7
`define ASSB_ADDR_ALARM_STICKY 16'h0200
`define ASSB_ADDR_RSVD_A 16'h0201
`define ASSB_ADDR_RSVD_B 16'h0202
`define ASSB_ADDR_RSVD_C 16'h0203
`define ASSB_ADDR_PHASE_ADJUST_BUSY_FLAGS 16'h0204
`define ASSB_BIT_REF0_LOS 0
`define ASSB_BIT_REF1_LOS 1
`define ASSB_BIT_HOLDOVER 4
`define ASSB_BIT_LOCK_LOSS 6
`define ASSB_STICKY_MASK 8'h53
`define ASSB_STICKY_RESET 8'h00
`define ASSB_ENABLE_RESET 8'h00
`define ASSB_OUTPUTS 8

`endif

// ==== assb_pkg.sv ====
// types for the alarm sticky status bank
package assb_pkg;
    typedef logic [7:0] assb_byte_t;
endpackage : assb_pkg

// ==== assb_sync.sv ====
// three-flop synchroniser with agreement filter for one bit
`timescale 1ns/1ns
`default_nettype none
module assb_sync
    import assb_pkg::*;
(
    input wire logic ref_clk, // device clock
    input wire logic reset_n, // async reset, active low
    input wire logic async_in, // level from outside the domain
    output logic sync_out // filtered level
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } assb_sync_state_t;

    assb_sync_state_t state_q;
    assb_sync_state_t state_d;

    always_comb begin
        state_d = state_q;
        state_d.stage = {state_q.stage[1:0], async_in};
        // change counts only once second and third flops agree
        if (state_q.stage[1] == state_q.stage[2]) begin
            state_d.level = state_q.stage[1];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.level;
endmodule : assb_sync
`default_nettype wire

// ==== assb_alarm_bank.sv ====
// sticky alarm status bank with enable register and busy flag readback
`include "assb_consts.svh"
`timescale 1ns/1ns
`default_nettype none
// How it works
// - any alarm event sets its sticky bit
// - sticky bit holds after alarm ends
// - only host write-one or reset clears a bit
// - bit 6 at 0200 latches lock loss
// - bit 4 at 0200 latches holdover
// - bits 0,1 latch reference 0,1 signal loss
// - byte 0204 shows per-output adjust busy
// - enable bits at 00C7 gate interrupt
module assb_alarm_bank
    import assb_pkg::*;
#(
    parameter int OUTPUTS = `ASSB_OUTPUTS
) (
    input wire logic ref_clk, // 25 MHz device clock
    input wire logic reset_n, // async reset, active low
    input wire logic [`ASSB_ADDR_W-1:0] reg_addr, // management port register address
    input wire logic reg_wr, // one-cycle write strobe
    input wire logic reg_rd, // one-cycle read strobe
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
    input wire logic lock_loss_alarm, // lock-loss alarm level, same clock
    input wire logic holdover_alarm, // holdover alarm level, same clock
    input wire logic ref0_los_alarm, // reference 0 signal-loss level, pin
    input wire logic ref1_los_alarm, // reference 1 signal-loss level, pin
    input wire logic [OUTPUTS-1:0] phase_adjust_active, // per-output busy
    output logic irq_out_n // interrupt, active low
);
    typedef struct packed {
        assb_byte_t sticky;
        assb_byte_t irq_allow;
        assb_byte_t rdata;
        logic irq_n;
    } assb_bank_state_t;

    assb_bank_state_t state_q;
    assb_bank_state_t state_d;
    logic ref0_los_sync;
    logic ref1_los_sync;
    assb_byte_t event_vec;
    assb_byte_t busy_vec;

    ////////////////////////////////////////////////////////////////////////
    // pin-level alarms are brought into the clock domain

    assb_sync u_ref0_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in(ref0_los_alarm),
        .sync_out(ref0_los_sync)
    );

    assb_sync u_ref1_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in(ref1_los_alarm),
        .sync_out(ref1_los_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // event vector and busy vector

    always_comb begin
        event_vec = 8'h00;
        event_vec[`ASSB_BIT_LOCK_LOSS] = lock_loss_alarm;
        event_vec[`ASSB_BIT_HOLDOVER] = holdover_alarm;
        event_vec[`ASSB_BIT_REF0_LOS] = ref0_los_sync;
        event_vec[`ASSB_BIT_REF1_LOS] = ref1_los_sync;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_busy
            if (gi < OUTPUTS) begin : g_on
                assign busy_vec[gi] = phase_adjust_active[gi];
            end else begin : g_off
                assign busy_vec[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // register file, sticky bits and interrupt

    always_comb begin
        state_d = state_q;
        // sticky write-one-clear, zeros ignored, event wins on a tie
        if (reg_wr && reg_addr == `ASSB_ADDR_ALARM_STICKY) begin
            state_d.sticky = state_q.sticky & ~(reg_wdata & `ASSB_STICKY_MASK);
        end
        state_d.sticky = state_d.sticky | event_vec;
        if (reg_wr && reg_addr == `ASSB_ADDR_ALARM_ENABLE) begin
            state_d.irq_allow = reg_wdata & `ASSB_STICKY_MASK;
        end
        if (reg_rd) begin
            case (reg_addr)
                `ASSB_ADDR_ALARM_STICKY: state_d.rdata = state_q.sticky;
                `ASSB_ADDR_ALARM_ENABLE: state_d.rdata = state_q.irq_allow;
                `ASSB_ADDR_PHASE_ADJUST_BUSY_FLAGS: state_d.rdata = busy_vec;
                default: state_d.rdata = 8'h00;
            endcase
        end
        state_d.irq_n = ~|(state_d.sticky & state_d.irq_allow);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q.sticky <= `ASSB_STICKY_RESET;
            state_q.irq_allow <= `ASSB_ENABLE_RESET;
            state_q.rdata <= 8'h00;
            state_q.irq_n <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign irq_out_n = state_q.irq_n;
endmodule : assb_alarm_bank
`default_nettype wire

// ==== assb_alarm_src.sv ====
// alarm and busy level source at the far side of the bank
`timescale 1ns/1ns
`default_nettype none
module assb_alarm_src (
    input wire logic ref_clk, // clock
    input wire logic [11:0] req, // wanted levels
    output logic [11:0] lvl = 12'h000 // levels toward the bank
);
    always @(posedge ref_clk) lvl <= req;
endmodule : assb_alarm_src
`default_nettype wire

// ==== assb_alarm_bank_props.sv ====
// port checks for the alarm bank
`timescale 1ns/1ns
`default_nettype none
module assb_alarm_bank_props import assb_pkg::*; #(
    parameter int OUTPUTS = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic lock_loss_alarm,
    input wire logic holdover_alarm,
    input wire logic ref0_los_alarm,
    input wire logic [OUTPUTS-1:0] phase_adjust_active,
    input wire logic irq_out_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic rs;
    assign rs = reg_rd && reg_addr == 16'h0200;
    chk_busy_read:
        assert property (reg_rd && reg_addr == 16'h0204 |=> reg_rdata == $past(phase_adjust_active))
        else $error("busy byte wrong");
    chk_lock_set:
        assert property (lock_loss_alarm ##1 rs |=> reg_rdata[6]) else $error("lock bit not set");
    chk_hold_set:
        assert property (holdover_alarm ##1 rs |=> reg_rdata[4]) else $error("hold bit not set");
    chk_ref0_set:
        assert property (ref0_los_alarm [*8] ##1 rs |=> reg_rdata[0]) else $error("ref0 bit not set");
    chk_bits_stay:
        assert property (rs && !reg_wr ##1 rs && !reg_wr |=> ($past(reg_rdata) & ~reg_rdata) == 8'h00)
        else $error("sticky bit dropped");
    chk_clear_one:
        assert property (reg_wr && reg_addr == 16'h0200 && reg_wdata[6] && !lock_loss_alarm ##1 rs
            |=> !reg_rdata[6]) else $error("clear failed");
    chk_irq_idle:
        assert property (rs |=> reg_rdata != 8'h00 || $past(irq_out_n)) else $error("irq without bit");
    chk_rsvd_zero:
        assert property (reg_rd && reg_addr inside {[16'h0201:16'h0203]} |=> reg_rdata == 8'h00)
        else $error("reserved read nonzero");
endmodule : assb_alarm_bank_props
`default_nettype wire

// ==== alarm_sticky_status_bank_tb_top.sv ====
// bench for the alarm sticky status bank
`timescale 1ns/1ns
`default_nettype none
module alarm_sticky_status_bank_tb_top;
    import assb_pkg::*;
    logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, irq_out_n;
    logic [15:0] reg_addr = 0;
    logic [11:0] req = 0, lvl;
    assb_byte_t reg_wdata = 0, reg_rdata;
    int failures = 0, compares = 0;
    initial forever #20 ref_clk = ~ref_clk;
    assb_alarm_src u_src (.ref_clk(ref_clk), .req(req), .lvl(lvl));
    assb_alarm_bank dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .lock_loss_alarm(lvl[0]), .holdover_alarm(lvl[1]), .ref0_los_alarm(lvl[2]),
        .ref1_los_alarm(lvl[3]), .phase_adjust_active(lvl[11:4]), .irq_out_n(irq_out_n));
    task chk(input assb_byte_t s, e, input string n);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task acc(input logic w, input logic [15:0] a, input assb_byte_t d);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
    endtask : acc
    task rd(input logic [15:0] a, input assb_byte_t e);
        acc(0, a, 8'h00);
        chk(reg_rdata, e, "reg_rdata");
    endtask : rd
    task idle(input int n);
        reg_wr = 0;
        reg_rd = 0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle
    task conclude;
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        conclude;
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 reset_n = 1;
        rd(16'h0200, 8'h00);
        rd(16'h00C7, 8'h00);
        rd(16'h0202, 8'h00);
        req = 12'h001;
        idle(2);
        req = 12'h000;
        idle(2);
        chk({7'h00, irq_out_n}, 8'h01, "irq_out_n");
        rd(16'h0200, 8'h40);
        rd(16'h0200, 8'h40);
        acc(1, 16'h00C7, 8'h53);
        rd(16'h00C7, 8'h53);
        chk({7'h00, irq_out_n}, 8'h00, "irq_out_n");
        acc(1, 16'h0200, 8'h13);
        rd(16'h0200, 8'h40);
        acc(1, 16'h0200, 8'h40);
        rd(16'h0200, 8'h00);
        chk({7'h00, irq_out_n}, 8'h01, "irq_out_n");
        req = 12'h00E;
        idle(10);
        acc(1, 16'h0200, 8'h13);
        rd(16'h0200, 8'h13);
        req = 12'h000;
        idle(6);
        acc(1, 16'h0200, 8'h53);
        rd(16'h0200, 8'h00);
        req = 12'hA50;
        idle(2);
        rd(16'h0204, 8'hA5);
        req = 12'h5A0;
        idle(2);
        rd(16'h0204, 8'h5A);
        req = 12'h000;
        idle(2);
        rd(16'h0204, 8'h00);
        conclude;
    end
endmodule : alarm_sticky_status_bank_tb_top
bind assb_alarm_bank assb_alarm_bank_props #(.OUTPUTS(OUTPUTS)) u_props (.*);
`default_nettype wire
